// >>> rtl/pcpi_top.v
// peak current pwm with slope ramp, blanking, burst and powerstage interlock
// assumes a same-clock avalon-mm master; comparator and enable are async pins
// Operation
// - every period starts with output on
// - output off when current exceeds reference
// - off decision from comparator versus dac
// - dac updates synchronised to period timer
// - zero reference forces outputs passive
// - reference falls by slope times elapsed time
// - zero slope keeps reference constant
// - comparator ignored during blanking interval
// - polarity selects active output level
// - dead time between complementary edges
// - three channels, single or complementary
// - burst alternates idle and running periods
// - burst enable switches burst controller
// - outputs disabled until enable rising edge
// - disabled outputs driven to passive level
// - no interlock means always enabled
// - active low status pin goes zero
// - active high status pin goes one
// - status pin indicative only, optional
//
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "pcpi_defines.vh"
module pcpi_top #(
    parameter NCH = 3,
    parameter DW = 16
) (
    input wire clk_sys,
    input wire arst_n,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire [NCH-1:0] comp_trip,
    input wire en_in,
    output reg [NCH-1:0] pwm_out,
    output reg [NCH-1:0] pwm_out_n,
    output reg [DW-1:0] dac_code,
    output reg dac_load,
    output reg en_status,
    output reg en_status_oe_n
);
    reg [31:0] ctrl_q;
    reg [DW-1:0] period_q, iref_q, slope_q, blank_q, dead_q, bper_q, bduty_q;
    reg [DW-1:0] cnt_q, ramp_q, bcnt_q;
    reg [NCH-1:0] cs1_q, cs2_q, trip_q;
    reg en1_q, en2_q, en3_q, unlock_q, brun_q, ack_q;
    wire [NCH-1:0] ch_a, ch_b;

    wire wrap = (cnt_q >= period_q);
    wire blanked = (cnt_q < blank_q);
    wire burst_wrap = (bcnt_q >= bper_q);
    wire pwm_en = ~ctrl_q[`PCPI_CTRL_LOCK_EN] | unlock_q;
    wire run = pwm_en & (iref_q != {DW{1'b0}}) & (brun_q | ~ctrl_q[`PCPI_CTRL_BURST_EN]);
    wire [DW:0] ramp_next = {1'b0, ramp_q} + {1'b0, slope_q};
    wire [DW-1:0] ramp_sat = ramp_next[DW] ? {DW{1'b1}} : ramp_next[DW-1:0];
    wire [DW-1:0] ref_eff = (ramp_q >= iref_q) ? {DW{1'b0}} : (iref_q - ramp_q);
    wire bus_req = (avs_read | avs_write) & avs_waitrequest & ~ack_q;

    // single-cycle wait: answer comes on the edge after the request is seen
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ack_q <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            ctrl_q <= `PCPI_RST_CTRL;
            period_q <= `PCPI_RST_PERIOD;
            iref_q <= {DW{1'b0}};
            slope_q <= {DW{1'b0}};
            blank_q <= `PCPI_RST_BLANK;
            dead_q <= `PCPI_RST_DEAD;
            bper_q <= `PCPI_RST_BPER;
            bduty_q <= {DW{1'b0}};
        end else begin
            ack_q <= bus_req;
            avs_waitrequest <= ~bus_req;
            // a write lands on the edge at which the master sees waitrequest low
            if (avs_write && !avs_waitrequest) begin
                case (avs_address)
                    `PCPI_ADDR_CTRL: ctrl_q <= avs_writedata;
                    `PCPI_ADDR_PERIOD: period_q <= avs_writedata[DW-1:0];
                    `PCPI_ADDR_IREF: iref_q <= avs_writedata[DW-1:0];
                    `PCPI_ADDR_SLOPE: slope_q <= avs_writedata[DW-1:0];
                    `PCPI_ADDR_BLANK: blank_q <= avs_writedata[DW-1:0];
                    `PCPI_ADDR_DEAD: dead_q <= avs_writedata[DW-1:0];
                    `PCPI_ADDR_BPER: bper_q <= avs_writedata[DW-1:0];
                    `PCPI_ADDR_BDUTY: bduty_q <= avs_writedata[DW-1:0];
                    default: ;
                endcase
            end
            if (bus_req && avs_read) begin
                case (avs_address)
                    `PCPI_ADDR_CTRL: avs_readdata <= ctrl_q;
                    `PCPI_ADDR_PERIOD: avs_readdata <= {{(32-DW){1'b0}}, period_q};
                    `PCPI_ADDR_IREF: avs_readdata <= {{(32-DW){1'b0}}, iref_q};
                    `PCPI_ADDR_SLOPE: avs_readdata <= {{(32-DW){1'b0}}, slope_q};
                    `PCPI_ADDR_BLANK: avs_readdata <= {{(32-DW){1'b0}}, blank_q};
                    `PCPI_ADDR_DEAD: avs_readdata <= {{(32-DW){1'b0}}, dead_q};
                    `PCPI_ADDR_BPER: avs_readdata <= {{(32-DW){1'b0}}, bper_q};
                    `PCPI_ADDR_BDUTY: avs_readdata <= {{(32-DW){1'b0}}, bduty_q};
                    `PCPI_ADDR_STATUS: avs_readdata <= {8'h00, {(8-NCH){1'b0}}, trip_q,
                        8'h00, 1'b0, brun_q, run, unlock_q, ref_eff[DW-1:DW-4]};
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // period timer, slope ramp and dac feed
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= {DW{1'b0}};
            ramp_q <= {DW{1'b0}};
            dac_code <= {DW{1'b0}};
            dac_load <= 1'b0;
        end else begin
            if (wrap) begin
                cnt_q <= {DW{1'b0}};
                ramp_q <= {DW{1'b0}};
            end else begin
                cnt_q <= cnt_q + {{(DW-1){1'b0}}, 1'b1};
                // a zero slope also flushes a ramp left from an earlier setting
                ramp_q <= (slope_q == {DW{1'b0}}) ? {DW{1'b0}} : ramp_sat;
            end
            dac_code <= ref_eff;
            dac_load <= 1'b1;
        end
    end

    // burst controller: running share of each burst period set by duty
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bcnt_q <= {DW{1'b0}};
            brun_q <= 1'b0;
        end else if (!ctrl_q[`PCPI_CTRL_BURST_EN]) begin
            bcnt_q <= {DW{1'b0}};
            brun_q <= 1'b1;
        end else if (wrap) begin
            bcnt_q <= burst_wrap ? {DW{1'b0}} : bcnt_q + {{(DW-1){1'b0}}, 1'b1};
            // duty is a fraction of full scale compared against period position
            brun_q <= ({bcnt_q, {DW{1'b0}}} < (bduty_q * (bper_q + {{(DW-1){1'b0}}, 1'b1})));
        end
    end

    // interlock enable input synchroniser and rising edge latch
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            // samples start high so an enable already high at reset is no edge
            en1_q <= 1'b1;
            en2_q <= 1'b1;
            en3_q <= 1'b1;
            unlock_q <= 1'b0;
            en_status <= 1'b0;
            en_status_oe_n <= 1'b1;
        end else begin
            en1_q <= en_in;
            en2_q <= en1_q;
            en3_q <= en2_q;
            if (en2_q && !en3_q)
                unlock_q <= 1'b1;
            en_status_oe_n <= ~ctrl_q[`PCPI_CTRL_ENPIN_EN];
            en_status <= ctrl_q[`PCPI_CTRL_ENPIN_HI] ? unlock_q : ~unlock_q;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi = gi + 1) begin : g_ch
            always @(posedge clk_sys or negedge arst_n) begin
                if (!arst_n) begin
                    cs1_q[gi] <= 1'b0;
                    cs2_q[gi] <= 1'b0;
                    trip_q[gi] <= 1'b0;
                end else begin
                    cs1_q[gi] <= comp_trip[gi];
                    cs2_q[gi] <= cs1_q[gi];
                    if (wrap)
                        trip_q[gi] <= 1'b0;
                    else if (cs2_q[gi] && !blanked)
                        trip_q[gi] <= 1'b1;
                end
            end
            pcpi_channel #(.DW(DW)) u_ch (
                .clk_sys(clk_sys),
                .arst_n(arst_n),
                .active(~trip_q[gi]),
                .run(run),
                .comp_mode(ctrl_q[`PCPI_CTRL_COMP0 + gi]),
                // channel drives its polarity input while not tripped, so invert it:
                // the configured level belongs to the tripped (current above) state
                .polarity(~ctrl_q[`PCPI_CTRL_POL0 + gi]),
                .idle_lvl(ctrl_q[`PCPI_CTRL_IDLE0 + gi]),
                .dead_cnt(dead_q),
                .out_a(ch_a[gi]),
                .out_b(ch_b[gi])
            );
        end
    endgenerate

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pwm_out <= {NCH{1'b0}};
            pwm_out_n <= {NCH{1'b0}};
        end else begin
            pwm_out <= ch_a;
            pwm_out_n <= ch_b;
        end
    end
endmodule

// >>> rtl/pcpi_defines.vh
// constants for the peak current pwm block with powerstage interlock
// included by the top-level design file only; holds definitions only
`ifndef PCPI_DEFINES_VH
`define PCPI_DEFINES_VH

`define PCPI_ADDR_CTRL 4'h0
`define PCPI_ADDR_PERIOD 4'h1
`define PCPI_ADDR_IREF 4'h2
`define PCPI_ADDR_SLOPE 4'h3
`define PCPI_ADDR_BLANK 4'h4
`define PCPI_ADDR_DEAD 4'h5
`define PCPI_ADDR_BPER 4'h6
`define PCPI_ADDR_BDUTY 4'h7
`define PCPI_ADDR_STATUS 4'h8

`define PCPI_CTRL_BURST_EN 0
`define PCPI_CTRL_LOCK_EN 1
`define PCPI_CTRL_ENPIN_EN 2
`define PCPI_CTRL_ENPIN_HI 3
`define PCPI_CTRL_POL0 4
`define PCPI_CTRL_COMP0 8
`define PCPI_CTRL_IDLE0 12

`define PCPI_RST_CTRL 32'h0000_0002
`define PCPI_RST_PERIOD 16'h03E7
`define PCPI_RST_BLANK 16'h000A
`define PCPI_RST_DEAD 16'h0005
`define PCPI_RST_BPER 16'h000A

`endif

// >>> rtl/pcpi_channel.v
// one output channel: single output or complementary pair with dead time
// assumes the raw active level is synchronous to clk_sys
`timescale 1ns/1ps
module pcpi_channel #(
    parameter DW = 16
) (
    input wire clk_sys,
    input wire arst_n,
    input wire active,
    input wire run,
    input wire comp_mode,
    input wire polarity,
    input wire idle_lvl,
    input wire [DW-1:0] dead_cnt,
    output reg out_a,
    output reg out_b
);
    reg [DW-1:0] cnt_q;
    reg last_q;
    wire settle = (cnt_q == {DW{1'b0}});

    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= {DW{1'b0}};
            last_q <= 1'b0;
            out_a <= 1'b0;
            out_b <= 1'b0;
        end else begin
            last_q <= active;
            if (active != last_q)
                cnt_q <= dead_cnt;
            else if (!settle)
                cnt_q <= cnt_q - {{(DW-1){1'b0}}, 1'b1};
            if (!run) begin
                out_a <= idle_lvl;
                out_b <= idle_lvl;
            end else if (!comp_mode) begin
                out_a <= active ? polarity : ~polarity;
                out_b <= idle_lvl;
            end else begin
                // both sides stay inactive until the dead time has run out
                out_a <= (active && settle && active == last_q) ? polarity : ~polarity;
                out_b <= (!active && settle && active == last_q) ? polarity : ~polarity;
            end
        end
    end
endmodule

// >>> bench/pcpi_asserts.sv
// port checker for pcpi_top
// bound from the bench; tracks config from bus writes the design takes
`timescale 1ns/1ps
module pcpi_asserts #(parameter NCH = 3, parameter DW = 16) (
    input wire clk_sys,
    input wire arst_n,
    input wire [3:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire en_in,
    input wire [NCH-1:0] pwm_out,
    input wire [DW-1:0] dac_code,
    input wire dac_load,
    input wire en_status,
    input wire en_status_oe_n
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    logic [31:0] ctrl_q;
    logic [DW-1:0] iref_q, slope_q;
    logic [7:0] cfg_age, en_age;
    logic en_prev_q;
    wire wr_take = avs_write && !avs_waitrequest;
    wire [NCH-1:0] idle = ctrl_q[12 +: NCH];
    // ages let registered and synchronised outputs settle before checking
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_q <= 32'h0000_0002;
            iref_q <= '0;
            slope_q <= '0;
            cfg_age <= 8'h00;
            en_age <= 8'h00;
            en_prev_q <= 1'b1;
        end else begin
            if (wr_take && avs_address == 4'h0) ctrl_q <= avs_writedata;
            if (wr_take && avs_address == 4'h2) iref_q <= avs_writedata[DW-1:0];
            if (wr_take && avs_address == 4'h3) slope_q <= avs_writedata[DW-1:0];
            cfg_age <= wr_take ? 8'h00 : (cfg_age == 8'hFF ? cfg_age : cfg_age + 8'h01);
            en_prev_q <= en_in;
            if (en_age != 8'h00 && en_age != 8'hFF) en_age <= en_age + 8'h01;
            else if (en_age == 8'h00 && en_in && !en_prev_q) en_age <= 8'h01;
        end
    end
    a_ack_single: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("ack held longer than one cycle");
    a_req_answered: assert property ((avs_read || avs_write) && avs_waitrequest
        |-> ##[1:3] !avs_waitrequest) else $error("request not answered");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 4'h8
        |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
    a_zero_ref_idle: assert property (cfg_age > 8 && iref_q == 0 |-> pwm_out == idle)
        else $error("zero reference not passive");
    a_locked_idle: assert property (cfg_age > 8 && ctrl_q[1] && en_age == 0
        |-> pwm_out == idle) else $error("locked outputs not passive");
    a_pin_drive: assert property (cfg_age > 8 |-> en_status_oe_n == !ctrl_q[2])
        else $error("status pin drive wrong");
    a_status_locked: assert property (cfg_age > 8 && ctrl_q[2:1] == 2'h3 && en_age == 0
        |-> en_status == !ctrl_q[3]) else $error("status wrong while locked");
    a_status_open: assert property (cfg_age > 8 && ctrl_q[2:1] == 2'h3 && en_age > 8
        |-> en_status == ctrl_q[3]) else $error("status wrong after unlock");
    a_dac_sync: assert property (cfg_age > 8 |-> dac_load)
        else $error("dac load missing");
    a_dac_flat: assert property (cfg_age > 8 && slope_q == 0 |-> dac_code == iref_q)
        else $error("reference not flat");
    cover property (en_age == 8'h01);
    cover property (wr_take && avs_address == 4'h2);
    cover property ($fell(pwm_out[0]));
endmodule

// >>> bench/pcpi_sense_model.sv
// inductor current sense and comparator model for one channel
// current ramps while the gate is on and collapses when it is off
`timescale 1ns/1ps
module pcpi_sense_model #(parameter DW = 16, parameter RATE = 16) (
    input wire clk_sys,
    input wire gate_on,
    input wire [DW-1:0] ref_code,
    output logic trip
);
    logic [DW:0] cur = '0;
    initial trip = 1'b0;
    always @(posedge clk_sys) begin
        cur <= gate_on ? cur + RATE : '0;
        trip <= gate_on && (cur > ref_code);
    end
endmodule

// >>> bench/pcpi_top_tb_top.sv
// self-checking bench for pcpi_top, sense model closing the loop on channel 0
// assumes one-cycle avalon answers and on level 1 with polarity and idle at 0
`timescale 1ns/1ps
module pcpi_top_tb_top;
    logic clk_sys = 1'b0, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, en_in = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic avs_waitrequest, dac_load, en_status, en_status_oe_n, trip0;
    logic [2:0] pwm_out, pwm_out_n;
    logic [15:0] dac_code;
    int n_fail = 0, samples_checked = 0, cyc = 0, cnt;
    typedef struct {logic [31:0] ctrl, iref, slope, bduty; int lo, hi;} row_t;
    // on-cycles over four 100-cycle periods; rate 16 per cycle, blanking 10
    // row 3 gives the ramp that long duty needs row 4 duty is one half
    // burst of three periods runs two, so a window holds two or three running
    row_t rows [5] = '{'{32'h2, 32'h200, 32'h0, 32'h0, 120, 176},
        '{32'h2, 32'h4, 32'h0, 32'h0, 44, 80}, '{32'h2, 32'h0, 32'h0, 32'h0, 0, 0},
        '{32'h2, 32'h200, 32'h8, 32'h0, 88, 124}, '{32'h3, 32'h200, 32'h0, 32'h8000, 60, 120}};
    always #5 clk_sys = ~clk_sys;
    pcpi_top u_pcpi_top (.*, .comp_trip({2'b00, trip0}));
    pcpi_sense_model u_pcpi_sense_model (.clk_sys(clk_sys), .gate_on(pwm_out[0]),
        .ref_code(dac_code), .trip(trip0));
    task automatic tally_and_finish;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input int lo, input int hi);
        samples_checked++;
        if (^got === 1'bx || got < lo || got > hi) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic bus(input bit we, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= we;
        avs_read <= !we;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic meas;
        cnt = 0;
        repeat (400) begin
            @(posedge clk_sys);
            if (pwm_out[0] === 1'b1) cnt++;
        end
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        bus(0, 4'h0, 32'h0);
        chk(rd, 2, 2);
        bus(0, 4'h1, 32'h0);
        chk(rd, 999, 999);
        bus(0, 4'h9, 32'h0);
        chk(rd, 0, 0);
        bus(1, 4'h1, 32'h63);
        bus(1, 4'h6, 32'h2);
        bus(1, 4'h2, 32'h200);
        meas;
        chk(cnt, 0, 0);
        $display("test locked done");
        en_in <= 1'b1;
        foreach (rows[i]) begin
            bus(1, 4'h0, rows[i].ctrl);
            bus(1, 4'h2, rows[i].iref);
            bus(1, 4'h3, rows[i].slope);
            bus(1, 4'h7, rows[i].bduty);
            repeat (200) @(posedge clk_sys);
            meas;
            chk(cnt, rows[i].lo, rows[i].hi);
            $display("test row %0d done", i);
        end
        // mid-run reset must relock; both status pin polarities
        for (int p = 0; p < 2; p++) begin
            arst_n <= 1'b0;
            en_in <= 1'b0;
            repeat (16) @(posedge clk_sys);
            arst_n <= 1'b1;
            bus(1, 4'h0, 32'h6 | (p << 3));
            repeat (8) @(posedge clk_sys);
            chk({en_status_oe_n, en_status}, !p, !p);
            en_in <= 1'b1;
            repeat (8) @(posedge clk_sys);
            chk({en_status_oe_n, en_status}, p, p);
            $display("test status pin %0d done", p);
        end
        tally_and_finish();
    end
endmodule
bind pcpi_top pcpi_asserts #(.NCH(NCH), .DW(DW)) u_pcpi_asserts (.*);
